/* File: logic/ctl_lit_pkg.sv */
// constants for the control, literal and table instruction decoder
package ctl_lit_pkg;
  localparam int PC_W = 21;
  localparam int TP_W = 22;
  localparam int PTR_W = 12;
  localparam int NUM_PTR = 3;
  localparam int STK_DEPTH = 31;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  // opcode fields
  localparam logic [3:0] OP_BRANCH = 4'hE;
  localparam logic [3:0] OP_OPERAND = 4'hF;
  localparam logic [3:0] OP_JUMP1 = 4'hF;
  localparam logic [3:0] OP_PTRLD1 = 4'hE;
  localparam logic [7:0] OP_BANK = 8'h01;
  localparam logic [7:0] OP_MISC = 8'h00;
  localparam logic [3:0] OP_LIT_RET = 4'hC;
  localparam logic [3:0] OP_ADD = 4'hF;
  localparam logic [3:0] OP_SUB = 4'h8;
  localparam logic [3:0] OP_AND = 4'hB;
  localparam logic [3:0] OP_OR = 4'h9;
  localparam logic [3:0] OP_XOR = 4'hA;
  localparam logic [3:0] OP_LOAD = 4'hE;
  localparam logic [3:0] OP_MUL = 4'hD;
  localparam logic [7:0] LO_STANDBY = 8'h03;
  localparam logic [7:0] LO_PUSH = 8'h05;
  localparam logic [7:0] LO_POP = 8'h06;
  localparam logic [6:0] LO_IRET = 7'h08;
  localparam logic [6:0] LO_RET = 7'h09;
  localparam logic [5:0] LO_TBL_RD = 6'h02;
  localparam logic [5:0] LO_TBL_WR = 6'h03;
  // table pointer modes
  localparam logic [1:0] TM_KEEP = 2'h0;
  localparam logic [1:0] TM_POST_INC = 2'h1;
  localparam logic [1:0] TM_POST_DEC = 2'h2;
  localparam logic [1:0] TM_PRE_INC = 2'h3;
  // extra no-operation cycles after the executing cycle, held as count minus one
  localparam logic [1:0] NOP_ONE = 2'h0;
  localparam logic [1:0] NOP_LONG_WR = 2'h3;
  // reset values of the power status bits
  localparam logic RST_WDT_EXPIRED = 1'b1;
  localparam logic RST_POWER_DOWN = 1'b1;
  typedef enum logic [1:0] {
    S_EXEC = 2'b00,
    S_NOP = 2'b01,
    S_WORD2 = 2'b10,
    S_STANDBY = 2'b11
  } state_e;
endpackage

/* File: logic/control_literal_table_decoder.sv */
// decode and execute of control, literal and table instructions
`timescale 1ns/10ps
module control_literal_table_decoder
  import ctl_lit_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [15:0] i_instr,
  input wire logic i_wake,
  input wire logic i_isr_low,
  input wire logic [7:0] i_tbl_rdata,
  input wire logic i_wr_long,
  input wire logic i_wr_done,
  input wire logic [7:0] i_port_pins,
  input wire logic [7:0] i_port_latch,
  input wire logic i_rmw_port,
  input wire logic i_timer_zero_rmw,
  input wire logic i_prescaler_assigned,
  output logic [ctl_lit_pkg::PC_W-1:0] o_pc,
  output logic o_busy,
  output logic [7:0] o_working_register,
  output logic [7:0] o_bank_select_register,
  output logic [ctl_lit_pkg::NUM_PTR*ctl_lit_pkg::PTR_W-1:0] o_indirect_pointer,
  output logic [4:0] o_alu_flags,
  output logic [15:0] o_product,
  output logic o_global_high_irq_enable,
  output logic o_peripheral_low_irq_enable,
  output logic o_watchdog_expired_flag,
  output logic o_power_down_flag,
  output logic o_standby,
  output logic [ctl_lit_pkg::PC_W-1:0] o_return_stack_top,
  output logic [ctl_lit_pkg::TP_W-1:0] o_tbl_addr,
  output logic o_tbl_rd,
  output logic o_tbl_wr,
  output logic [7:0] o_tbl_wdata,
  output logic o_wr_busy,
  output logic [7:0] o_rmw_operand,
  output logic o_prescaler_clear
);
  import ctl_lit_pkg::*;

  typedef struct packed {
    state_e st;
    logic [1:0] nop;
    logic [PC_W-1:0] pc;
    logic [7:0] w;
    logic [7:0] bank_select_register;
    logic [NUM_PTR-1:0][PTR_W-1:0] ptr;
    logic c, dc, z, ov, n;
    logic gie, peie, to, pd;
    logic [4:0] sp;
    logic [STK_DEPTH-1:0][PC_W-1:0] stk;
    logic [15:0] hold;
    logic [15:0] prod;
    logic [TP_W-1:0] tptr;
    logic [TP_W-1:0] taddr;
    logic [7:0] tlat;
    logic rd_pend, trd, twr, wbusy;
    logic [7:0] pin1, pin2, rmw;
    logic pclr;
    logic busy, sby;
    logic [PC_W-1:0] return_stack_top;
  } core_s;

  core_s r_reg;
  core_s r_next;
  logic [PC_W-1:0] pc_inc;
  logic [7:0] k;
  logic [7:0] add_a;
  logic [7:0] add_b;
  logic add_ci;
  logic [8:0] sum;
  logic [4:0] half;
  logic br_true;
  logic [3:0] flag_vec;

  // shared adder; subtraction is literal plus inverted working register plus one
  always_comb
  begin
    k = i_instr[7:0];
    pc_inc = r_reg.pc + PC_STEP;
    add_a = k;
    add_b = (i_instr[11:8] == OP_SUB) ? ~r_reg.w : r_reg.w;
    add_ci = (i_instr[11:8] == OP_SUB);
    sum = {1'b0, add_a} + {1'b0, add_b} + {8'h00, add_ci};
    half = {1'b0, add_a[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_ci};
    flag_vec = {r_reg.n, r_reg.ov, r_reg.c, r_reg.z};
    br_true = flag_vec[i_instr[10:9]] ^ i_instr[8];
  end

  // next-state logic for the whole core
  always_comb
  begin
    r_next = r_reg;
    r_next.trd = 1'b0;
    r_next.twr = 1'b0;
    r_next.rd_pend = 1'b0;
    // pins are synchronised before the operand mux reads them
    r_next.pin1 = i_port_pins;
    r_next.pin2 = r_reg.pin1;
    r_next.rmw = i_rmw_port ? r_reg.pin2 : i_port_latch;
    r_next.pclr = i_timer_zero_rmw & i_prescaler_assigned;
    if (r_reg.rd_pend)
      r_next.tlat = i_tbl_rdata;
    // started write ends only on its own done, not on later instructions
    if (r_reg.wbusy && i_wr_done)
      r_next.wbusy = 1'b0;
    unique case (r_reg.st)
      S_STANDBY:
      begin
        if (i_wake)
          r_next.st = S_EXEC;
      end
      S_NOP:
      begin
        // fetched word is discarded; pc already points at the target
        if (r_reg.nop == NOP_ONE)
          r_next.st = S_EXEC;
        else
          r_next.nop = r_reg.nop - 2'h1;
      end
      S_WORD2:
      begin
        r_next.st = S_EXEC;
        r_next.pc = pc_inc;
        // second word is consumed here and never executed on its own
        if (i_instr[15:12] == OP_OPERAND && r_reg.hold[11:8] == OP_JUMP1)
          r_next.pc = {i_instr[11:0], r_reg.hold[7:0], 1'b0};
        else if (i_instr[15:12] == OP_OPERAND)
          r_next.ptr[r_reg.hold[5:4]] = {r_reg.hold[3:0], i_instr[7:0]};
      end
      S_EXEC:
      begin
        r_next.pc = pc_inc;
        if (i_instr[15:12] == OP_BRANCH)
        begin
          if (i_instr[11:8] == OP_JUMP1 ||
              (i_instr[11:8] == OP_PTRLD1 && i_instr[7:6] == 2'h0 && i_instr[5:4] != 2'h3))
          begin
            r_next.hold = i_instr;
            r_next.st = S_WORD2;
          end
          else if (!i_instr[11] && br_true)
          begin
            r_next.pc = pc_inc + {{(PC_W-9){k[7]}}, k, 1'b0};
            r_next.st = S_NOP;
            r_next.nop = NOP_ONE;
          end
        end
        else if (i_instr[15:8] == OP_MISC)
        begin
          if (k == LO_STANDBY)
          begin
            r_next.st = S_STANDBY;
            r_next.to = 1'b1;
            r_next.pd = 1'b0;
          end
          else if (k == LO_PUSH && r_reg.sp < 5'(STK_DEPTH))
          begin
            r_next.stk[r_reg.sp] = pc_inc;
            r_next.sp = r_reg.sp + 5'h01;
          end
          else if (k == LO_POP && r_reg.sp != 5'h00)
            r_next.sp = r_reg.sp - 5'h01;
          else if (k[7:1] == LO_IRET || k[7:1] == LO_RET)
          begin
            // empty stack returns to address zero
            r_next.pc = (r_reg.sp == 5'h00) ? '0 : r_reg.stk[r_reg.sp - 5'h01];
            r_next.sp = (r_reg.sp == 5'h00) ? 5'h00 : r_reg.sp - 5'h01;
            r_next.st = S_NOP;
            r_next.nop = NOP_ONE;
            if (k[7:1] == LO_IRET && i_isr_low)
              r_next.peie = 1'b1;
            else if (k[7:1] == LO_IRET)
              r_next.gie = 1'b1;
          end
          else if (k[7:2] == LO_TBL_RD || k[7:2] == LO_TBL_WR)
          begin
            r_next.st = S_NOP;
            r_next.nop = NOP_ONE;
            r_next.taddr = (k[1:0] == TM_PRE_INC) ? r_reg.tptr + 22'h1 : r_reg.tptr;
            unique case (k[1:0])
              TM_KEEP: r_next.tptr = r_reg.tptr;
              TM_POST_INC, TM_PRE_INC: r_next.tptr = r_reg.tptr + 22'h1;
              TM_POST_DEC: r_next.tptr = r_reg.tptr - 22'h1;
            endcase
            if (k[7:2] == LO_TBL_RD)
            begin
              r_next.trd = 1'b1;
              r_next.rd_pend = 1'b1;
            end
            else
            begin
              r_next.twr = 1'b1;
              if (i_wr_long)
              begin
                r_next.nop = NOP_LONG_WR;
                r_next.wbusy = 1'b1;
              end
            end
          end
        end
        else if (i_instr[15:8] == OP_BANK && i_instr[7:4] == 4'h0)
          r_next.bank_select_register = {4'h0, k[3:0]};
        else if (i_instr[15:12] == 4'h0 && i_instr[11])
        begin
          unique case (i_instr[11:8])
            OP_ADD, OP_SUB:
            begin
              r_next.w = sum[7:0];
              r_next.c = sum[8];
              r_next.dc = half[4];
              r_next.ov = (add_a[7] == add_b[7]) && (sum[7] != add_a[7]);
              r_next.z = (sum[7:0] == 8'h00);
              r_next.n = sum[7];
            end
            OP_AND, OP_OR, OP_XOR:
            begin
              r_next.w = (i_instr[11:8] == OP_AND) ? (r_reg.w & k) :
                         (i_instr[11:8] == OP_OR) ? (r_reg.w | k) : (r_reg.w ^ k);
              r_next.z = (r_next.w == 8'h00);
              r_next.n = r_next.w[7];
            end
            OP_LOAD: r_next.w = k;
            OP_MUL: r_next.prod = 16'(r_reg.w) * 16'(k);
            OP_LIT_RET:
            begin
              r_next.w = k;
              r_next.pc = (r_reg.sp == 5'h00) ? '0 : r_reg.stk[r_reg.sp - 5'h01];
              r_next.sp = (r_reg.sp == 5'h00) ? 5'h00 : r_reg.sp - 5'h01;
              r_next.st = S_NOP;
              r_next.nop = NOP_ONE;
            end
          endcase
        end
        // stray operand words and all other codes fall through as no-ops
      end
    endcase
    // status outputs come from the next state so they leave a flop in step with the state bits
    r_next.busy = (r_next.st != S_EXEC);
    r_next.sby = (r_next.st == S_STANDBY);
    r_next.return_stack_top = (r_next.sp == 5'h00) ? '0 : r_next.stk[r_next.sp - 5'h01];
  end

  // single state register; power status bits come up set
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      r_reg <= '0;
      r_reg.to <= RST_WDT_EXPIRED;
      r_reg.pd <= RST_POWER_DOWN;
    end
    else
      r_reg <= r_next;
  end

  assign o_pc = r_reg.pc;
  assign o_busy = r_reg.busy;
  assign o_working_register = r_reg.w;
  assign o_bank_select_register = r_reg.bank_select_register;
  assign o_indirect_pointer = r_reg.ptr;
  assign o_alu_flags = {r_reg.n, r_reg.ov, r_reg.z, r_reg.dc, r_reg.c};
  assign o_product = r_reg.prod;
  assign o_global_high_irq_enable = r_reg.gie;
  assign o_peripheral_low_irq_enable = r_reg.peie;
  assign o_watchdog_expired_flag = r_reg.to;
  assign o_power_down_flag = r_reg.pd;
  assign o_standby = r_reg.sby;
  assign o_return_stack_top = r_reg.return_stack_top;
  assign o_tbl_addr = r_reg.taddr;
  assign o_tbl_rd = r_reg.trd;
  assign o_tbl_wr = r_reg.twr;
  assign o_tbl_wdata = r_reg.tlat;
  assign o_wr_busy = r_reg.wbusy;
  assign o_rmw_operand = r_reg.rmw;
  assign o_prescaler_clear = r_reg.pclr;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic ex;
  logic [PC_W-1:0] br_tgt;
  logic [8:0] add_exp;
  assign ex = (r_reg.st == S_EXEC);
  // expected values rebuilt from the instruction word, not taken from the datapath
  assign br_tgt = r_reg.pc + PC_STEP + {{(PC_W-9){i_instr[7]}}, i_instr[7:0], 1'b0};
  assign add_exp = {1'b0, r_reg.w} + {1'b0, i_instr[7:0]};

  property p_branch_taken;
    ex && i_instr[15:11] == 5'h1C && br_true |=> r_reg.pc == $past(br_tgt);
  endproperty
  a_branch_taken: assert property (p_branch_taken) else $error("taken branch target wrong");
  property p_branch_untaken;
    ex && i_instr[15:11] == 5'h1C && !br_true |=> r_reg.st == S_EXEC && r_reg.pc == $past(pc_inc);
  endproperty
  a_branch_untaken: assert property (p_branch_untaken) else $error("untaken branch not one cycle");

  property p_jump;
    r_reg.st == S_WORD2 && r_reg.hold[11:8] == OP_JUMP1 && i_instr[15:12] == OP_OPERAND
      |=> r_reg.pc == {$past(i_instr[11:0]), $past(r_reg.hold[7:0]), 1'b0} && r_reg.st == S_EXEC;
  endproperty
  a_jump: assert property (p_jump) else $error("jump target wrong");

  property p_stray_operand;
    ex && i_instr[15:12] == OP_OPERAND |=> $stable(r_reg.w) && $stable(o_alu_flags) && r_reg.st == S_EXEC;
  endproperty
  a_stray_operand: assert property (p_stray_operand) else $error("stray operand word not a no-op");
  property p_add;
    ex && i_instr[15:8] == 8'h0F |=> {r_reg.c, r_reg.w} == $past(add_exp) && r_reg.z == (r_reg.w == 8'h00);
  endproperty
  a_add: assert property (p_add) else $error("add literal wrong");
  property p_load;
    ex && i_instr[15:8] == 8'h0E |=> r_reg.w == $past(k) && $stable(o_alu_flags);
  endproperty
  a_load: assert property (p_load) else $error("load literal wrong");

  property p_pop;
    ex && i_instr == 16'h0006 && r_reg.sp != 5'h00 |=> r_reg.sp == $past(r_reg.sp) - 5'h01 && r_reg.st == S_EXEC;
  endproperty
  a_pop: assert property (p_pop) else $error("pop did not drop stack top");

  property p_standby;
    ex && i_instr == 16'h0003 |=> o_standby && o_watchdog_expired_flag && !o_power_down_flag;
  endproperty
  a_standby: assert property (p_standby) else $error("standby entry wrong");

  property p_long_write;
    ex && i_instr[15:2] == 14'h0003 && i_wr_long |=> (r_reg.st == S_NOP) [*4] ##1 r_reg.st == S_EXEC;
  endproperty
  a_long_write: assert property (p_long_write) else $error("long table write not five cycles");

  property p_write_holds;
    r_reg.wbusy && !i_wr_done |=> r_reg.wbusy;
  endproperty
  a_write_holds: assert property (p_write_holds) else $error("write cycle dropped early");

  property p_prescaler;
    i_timer_zero_rmw && i_prescaler_assigned |=> o_prescaler_clear;
  endproperty
  a_prescaler: assert property (p_prescaler) else $error("prescaler not cleared");
endmodule // control_literal_table_decoder

/* File: verif/prog_memory_model.sv */
// program memory model that feeds instruction words to the decoder
`timescale 1ns/10ps
module prog_memory_model
(
  input wire logic [ctl_lit_pkg::PC_W-1:0] i_pc,
  output logic [15:0] o_word
);
  import ctl_lit_pkg::*;
  logic [15:0] words [256];
  // combinational read by word; the odd byte bit is ignored and the space wraps
  assign o_word = words[i_pc[8:1]];
endmodule // prog_memory_model

/* File: verif/control_literal_table_decoder_bench.sv */
// self-checking bench for the control, literal and table decoder
`timescale 1ns/10ps
module control_literal_table_decoder_bench;
  import ctl_lit_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  wire logic [15:0] i_instr;
  logic i_wake = 1'b0;
  logic i_isr_low = 1'b0;
  logic [7:0] i_tbl_rdata = 8'h00;
  logic i_wr_long = 1'b0;
  logic i_wr_done = 1'b0;
  logic [7:0] i_port_pins = 8'h3C;
  logic [7:0] i_port_latch = 8'hC3;
  logic i_rmw_port = 1'b0;
  logic i_timer_zero_rmw = 1'b0;
  logic i_prescaler_assigned = 1'b0;
  logic [PC_W-1:0] o_pc;
  logic o_busy;
  logic [7:0] o_working_register;
  logic [7:0] o_bank_select_register;
  logic [NUM_PTR*PTR_W-1:0] o_indirect_pointer;
  logic [4:0] o_alu_flags;
  logic [15:0] o_product;
  logic o_global_high_irq_enable;
  logic o_peripheral_low_irq_enable;
  logic o_watchdog_expired_flag;
  logic o_power_down_flag;
  logic o_standby;
  logic [PC_W-1:0] o_return_stack_top;
  logic [TP_W-1:0] o_tbl_addr;
  logic o_tbl_rd;
  logic o_tbl_wr;
  logic [7:0] o_tbl_wdata;
  logic o_wr_busy;
  logic [7:0] o_rmw_operand;
  logic o_prescaler_clear;
  int n_mismatch = 0;
  int checks = 0;
  int cyc;
  int n_rd;
  int n_wr;
  logic [15:0] q[$];
  logic [3:0] bits;
  logic tk;
  logic [4:0] fs [3] = '{5'h00, 5'h1B, 5'h04};
  logic [7:0] ws [3] = '{8'h00, 8'h90, 8'h00};
  logic [15:0] rw [4] = '{16'h0C33, 16'h0013, 16'h0010, 16'h0011};

  control_literal_table_decoder uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_instr(i_instr), .i_wake(i_wake),
    .i_isr_low(i_isr_low), .i_tbl_rdata(i_tbl_rdata), .i_wr_long(i_wr_long), .i_wr_done(i_wr_done),
    .i_port_pins(i_port_pins), .i_port_latch(i_port_latch), .i_rmw_port(i_rmw_port), .i_timer_zero_rmw(i_timer_zero_rmw),
    .i_prescaler_assigned(i_prescaler_assigned), .o_pc(o_pc), .o_busy(o_busy),
    .o_working_register(o_working_register), .o_bank_select_register(o_bank_select_register),
    .o_indirect_pointer(o_indirect_pointer), .o_alu_flags(o_alu_flags), .o_product(o_product),
    .o_global_high_irq_enable(o_global_high_irq_enable), .o_peripheral_low_irq_enable(o_peripheral_low_irq_enable),
    .o_watchdog_expired_flag(o_watchdog_expired_flag), .o_power_down_flag(o_power_down_flag),
    .o_standby(o_standby), .o_return_stack_top(o_return_stack_top), .o_tbl_addr(o_tbl_addr), .o_tbl_rd(o_tbl_rd),
    .o_tbl_wr(o_tbl_wr), .o_tbl_wdata(o_tbl_wdata), .o_wr_busy(o_wr_busy), .o_rmw_operand(o_rmw_operand),
    .o_prescaler_clear(o_prescaler_clear));
  prog_memory_model mem (.i_pc(o_pc), .o_word(i_instr));

  // 40 MHz core clock
  always #12.5 i_clk = ~i_clk;

  // table memory stand-in: data follows the address so each read is traceable
  always @(negedge i_clk) i_tbl_rdata <= o_tbl_addr[7:0] ^ 8'hA5;

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
    begin
      $display("bench passed");
    end
    else
    begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // reset for four cycles; release on a falling edge so the first word runs at the next rise
  task automatic rst();
    @(negedge i_clk);
    i_rst_n = 1'b0;
    repeat (4) @(negedge i_clk);
    chk(o_power_down_flag, 1'b1);
    chk(o_working_register, 8'h00);
    i_rst_n = 1'b1;
  endtask

  // load the program in q, reset, and count cycles until standby
  task automatic run();
    foreach (mem.words[i]) mem.words[i] = 16'h0000;
    foreach (q[i]) mem.words[i] = q[i];
    rst();
    cyc = 0;
    n_rd = 0;
    n_wr = 0;
    do
    begin
      @(negedge i_clk);
      cyc++;
      // table strobes stand one cycle, so each is counted at the falling edge it shows on
      n_rd += o_tbl_rd;
      n_wr += o_tbl_wr;
    end while (o_standby !== 1'b1 && cyc < 200);
  endtask

  // common end-of-program comparisons
  task automatic fin(input int ncyc, input logic [7:0] w, input logic [4:0] f);
    chk(cyc, ncyc);
    chk(o_working_register, w);
    chk(o_alu_flags, f);
    chk(o_watchdog_expired_flag, 1'b1);
    chk(o_power_down_flag, 1'b0);
    chk(o_busy, 1'b1);
  endtask

  // watchdog: the whole suite needs about four hundred cycles
  initial
  begin
    repeat (20000) @(posedge i_clk);
    n_mismatch++;
    print_verdict();
  end

  // main test sequence
  initial
  begin
    q = {16'h0E88, 16'h0F88, 16'h0B0F, 16'h0E80, 16'h0D02, 16'h0003};
    run();
    fin(6, 8'h80, 5'h0F);
    chk(o_product, 16'h0100);
    i_wake = 1'b1;
    @(negedge i_clk);
    chk(o_standby, 1'b0);
    chk(o_busy, 1'b0);
    i_wake = 1'b0;
    $display("test add_and_logic done");
    q = {16'h0E01, 16'h0880, 16'h0A7F, 16'h0980, 16'h0107, 16'h0002, 16'h0020, 16'h0003};
    run();
    fin(8, 8'h80, 5'h19);
    chk(o_bank_select_register, 8'h07);
    $display("test sub_and_bank done");
    for (int s = 0; s < 3; s++)
    begin
      for (int c = 0; c < 8; c++)
      begin
        q = {};
        if (s == 1) q = {16'h0E88, 16'h0F88, 16'h0980};
        if (s == 2) q = {16'h0B00};
        q.push_back(16'hE001 | 16'(c << 8));
        q.push_back(16'h0E11);
        q.push_back(16'h0003);
        bits = {fs[s][4], fs[s][3], fs[s][0], fs[s][2]};
        tk = bits[c / 2] ^ c[0];
        run();
        fin(q.size(), tk ? ws[s] : 8'h11, fs[s]);
      end
    end
    $display("test branches done");
    q = {16'hF0AB, 16'hEF04, 16'hF000, 16'h0E11, 16'h0E22, 16'h0003};
    run();
    fin(5, 8'h22, 5'h00);
    chk(o_pc, 21'h00000C);
    $display("test jump done");
    for (int v = 0; v < 4; v++)
    begin
      i_isr_low = (v == 3);
      q = {16'h0005, 16'hE102, 16'h0003, 16'h0E77, 16'h0B00, rw[v]};
      run();
      fin(8, (v == 0) ? 8'h33 : 8'h00, 5'h04);
      chk(o_return_stack_top, 21'h0);
      chk(o_global_high_irq_enable, v == 2);
      chk(o_peripheral_low_irq_enable, v == 3);
    end
    q = {16'h0005, 16'h0005, 16'h0006, 16'h0003};
    run();
    fin(4, 8'h00, 5'h00);
    chk(o_return_stack_top, 21'h2);
    $display("test returns done");
    q = {16'hEE15, 16'hF0AB, 16'h000A, 16'h000B, 16'h0009, 16'h0008, 16'h0003};
    run();
    fin(11, 8'h00, 5'h00);
    chk(o_indirect_pointer, 36'h005AB000);
    chk(o_tbl_addr, 22'h1);
    chk(o_tbl_wdata, 8'hA4);
    chk(n_rd, 4);
    chk(n_wr, 0);
    for (int wl = 0; wl < 2; wl++)
    begin
      i_wr_long = wl[0];
      q = {16'h000E, 16'h000F, 16'h000C, 16'h000D, 16'h0003};
      run();
      fin(wl ? 21 : 9, 8'h00, 5'h00);
      chk(o_tbl_addr, 22'h0);
      chk(n_wr, 4);
      chk(o_wr_busy, wl[0]);
      i_wr_done = 1'b1;
      @(negedge i_clk);
      i_wr_done = 1'b0;
      @(negedge i_clk);
      chk(o_wr_busy, 1'b0);
    end
    i_wr_long = 1'b0;
    $display("test table done");
    // pins and latch differ on every bit, so the chosen source is unmistakable
    foreach (mem.words[i]) mem.words[i] = 16'h0000;
    rst();
    i_rmw_port = 1'b1;
    repeat (4) @(negedge i_clk);
    chk(o_rmw_operand, 8'h3C);
    i_rmw_port = 1'b0;
    repeat (2) @(negedge i_clk);
    chk(o_rmw_operand, 8'hC3);
    for (int a = 0; a < 2; a++)
    begin
      i_prescaler_assigned = a[0];
      i_timer_zero_rmw = 1'b1;
      @(negedge i_clk);
      i_timer_zero_rmw = 1'b0;
      chk(o_prescaler_clear, a[0]);
      @(negedge i_clk);
      chk(o_prescaler_clear, 1'b0);
    end
    $display("test port_and_timer done");
    print_verdict();
  end
endmodule // control_literal_table_decoder_bench
